// ### tb/sll_board.sv
// Board model: strap resistors seen while the pads float, LED levels while driven.
`timescale 1ns/10ps
module sll_board (
	input  wire logic strap_reg,
	input  wire logic strap_irq,
	input  wire logic link_activity_led,
	input  wire logic link_activity_led_oe_n,
	input  wire logic link_speed_led,
	input  wire logic link_speed_led_oe_n,
	output logic      pad_act_strap_in,
	output logic      pad_spd_strap_in
);
	assign pad_act_strap_in = link_activity_led_oe_n ? strap_reg : link_activity_led;
	assign pad_spd_strap_in = link_speed_led_oe_n ? strap_irq : link_speed_led;
endmodule

// ### tb/tb.sv
// Self-checking bench for the strap latch and link LED block.
`timescale 1ns/10ps
module tb;
	logic clk, rstn, system_reset_n, link_up, link_activity, speed_100, line_isolate;
	logic phy_irq, tx_error, strap_reg, strap_irq, pad_act_strap_in, pad_spd_strap_in;
	logic link_activity_led, link_activity_led_oe_n, link_speed_led, link_speed_led_oe_n;
	logic regulator_off, irq_mode, interrupt_request_n, transmit_symbol_bit_four;
	int   n_errors = 0, n_checks = 0, cycles = 0, dark, lit;
	sll_top #(.BLINK_CYC(4)) u_dut (.clk, .rstn, .system_reset_n, .pad_act_strap_in,
		.pad_spd_strap_in,
		.link_up, .link_activity, .speed_100, .line_isolate, .phy_irq, .tx_error,
		.link_activity_led, .link_activity_led_oe_n, .link_speed_led, .link_speed_led_oe_n,
		.regulator_off, .irq_mode, .interrupt_request_n, .transmit_symbol_bit_four);
	sll_board u_board (.strap_reg, .strap_irq, .link_activity_led, .link_activity_led_oe_n,
		.link_speed_led, .link_speed_led_oe_n, .pad_act_strap_in, .pad_spd_strap_in);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	task chk(string nm, logic got, logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task step(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task t_power;
		@(posedge clk);
		rstn <= 1'h1;
		tx_error <= 1'h1;
		phy_irq <= 1'h1;
		step(8);
		chk("led_oe_n", link_activity_led_oe_n, 1'h0);
		chk("reg_off", regulator_off, 1'h1);
		chk("irq_mode", irq_mode, 1'h0);
		chk("sym4", transmit_symbol_bit_four, 1'h1);
		chk("irq_n", interrupt_request_n, 1'h1);
	endtask
	task t_sysrst;
		@(posedge clk);
		system_reset_n <= 1'h0;
		step(4);
		chk("oe_n_in_rst", link_speed_led_oe_n, 1'h1);
		@(posedge clk);
		strap_reg <= 1'h0;
		strap_irq <= 1'h1;
		system_reset_n <= 1'h1;
		step(8);
		chk("reg_on", regulator_off, 1'h0);
		chk("irq_sel", irq_mode, 1'h1);
		chk("irq_n_on", interrupt_request_n, 1'h0);
		chk("sym4_off", transmit_symbol_bit_four, 1'h0);
		@(posedge clk);
		phy_irq <= 1'h0;
		step(2);
		chk("irq_n_idle", interrupt_request_n, 1'h1);
	endtask
	task t_leds;
		@(posedge clk);
		link_up <= 1'h1;
		speed_100 <= 1'h1;
		step(2);
		chk("spd_100", link_speed_led, 1'h1);
		chk("link_lit", link_activity_led, 1'h1);
		@(posedge clk);
		line_isolate <= 1'h1;
		step(2);
		chk("spd_iso", link_speed_led, 1'h0);
		@(posedge clk);
		line_isolate <= 1'h0;
		speed_100 <= 1'h0;
		link_activity <= 1'h1;
		dark = 0;
		lit = 0;
		step(2);
		chk("spd_10", link_speed_led, 1'h0);
		repeat (24) begin
			if (link_activity_led === 1'h1) lit++;
			else dark++;
			step(1);
		end
		chk("blink_dark", dark > 0, 1'h1);
		chk("blink_lit", lit > 0, 1'h1);
		@(posedge clk);
		link_up <= 1'h0;
		step(2);
		chk("act_down", link_activity_led, 1'h0);
	endtask
	task tally_and_finish;
		if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{rstn, link_up, link_activity, speed_100, line_isolate, phy_irq, tx_error} = 7'h0;
		system_reset_n = 1'h1;
		strap_reg = 1'h1;
		strap_irq = 1'h0;
		repeat (5) @(posedge clk);
		t_power;
		t_sysrst;
		t_leds;
		tally_and_finish;
	end
endmodule

// ### verilog/sll_pkg.sv
// Constants and types shared by the strap latch and link LED block.
package sll_pkg;
	localparam logic [1:0]  SYNC_RST_VAL      = 2'h0;
	localparam logic        REG_DIS_RST_VAL   = 1'h0;
	localparam logic        IRQSEL_RST_VAL    = 1'h1;
	localparam int          CLK_HZ            = 40000000;
	localparam int          BLINK_HALF_MS     = 40;
	localparam int          BLINK_HALF_CYC    = (CLK_HZ / 1000) * BLINK_HALF_MS;
	localparam int          STRAP_HOLD_CYC    = 2;
	typedef enum logic [1:0] {SLL_RESET, SLL_SAMPLE, SLL_RUN} sll_state_t;
endpackage

// ### verilog/sll_top.sv
// Strap capture at reset and shared LED pin drive afterwards.
// Functional notes
// - Straps captured at power-on and system reset.
// - System reset input is active low.
// - Activity LED lit on link, blinks traffic.
// - Speed LED on at 100 with link up and line not isolated, off otherwise.
// - Regulator-disable strap high turns regulator off.
// - Interrupt strap high selects interrupt output.
`timescale 1ns/10ps
module sll_top import sll_pkg::*; #(
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic system_reset_n,
	input  wire logic pad_act_strap_in,
	input  wire logic pad_spd_strap_in,
	input  wire logic link_up,
	input  wire logic link_activity,
	input  wire logic speed_100,
	input  wire logic line_isolate,
	input  wire logic phy_irq,
	input  wire logic tx_error,
	output logic      link_activity_led,
	output logic      link_activity_led_oe_n,
	output logic      link_speed_led,
	output logic      link_speed_led_oe_n,
	output logic      regulator_off,
	output logic      irq_mode,
	output logic      interrupt_request_n,
	output logic      transmit_symbol_bit_four
);
	logic [1:0] rst_sync_ff, s1_sync_ff, s2_sync_ff;
	logic       sys_rst_s;
	sll_state_t state_ff, nxt_state;
	logic       regulator_disable_strap_ff, nxt_regulator_disable_strap;
	logic       irq_pin_function_strap_ff, nxt_irq_pin_function_strap;
	logic [31:0] blink_cnt_ff, nxt_blink_cnt;
	logic       blink_ff, nxt_blink;
	logic       act_led_ff, nxt_act_led, spd_led_ff, nxt_spd_led;
	logic       int_n_ff, nxt_int_n, txsym4_ff, nxt_txsym4;
	logic [1:0] hold_cnt_ff, nxt_hold_cnt;

	// Two-flop synchronisers for the reset pin and both strap pads.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rst_sync_ff <= SYNC_RST_VAL;
			s1_sync_ff  <= SYNC_RST_VAL;
			s2_sync_ff  <= SYNC_RST_VAL;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], system_reset_n};
			s1_sync_ff  <= {s1_sync_ff[0], pad_act_strap_in};
			s2_sync_ff  <= {s2_sync_ff[0], pad_spd_strap_in};
		end
	end
	assign sys_rst_s = !rst_sync_ff[1];

	// Hold-off counter keeps the pads released until the strap synchronisers refill.
	always_comb begin
		nxt_hold_cnt = hold_cnt_ff;
		if (state_ff != SLL_RESET) begin
			nxt_hold_cnt = 2'h0;
		end else if (hold_cnt_ff < 2'(STRAP_HOLD_CYC - 1)) begin
			nxt_hold_cnt = hold_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hold_cnt_ff <= 2'h0;
		end else begin
			hold_cnt_ff <= nxt_hold_cnt;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_regulator_disable_strap = regulator_disable_strap_ff;
		nxt_irq_pin_function_strap  = irq_pin_function_strap_ff;
		case (state_ff)
			SLL_RESET: begin
				if (!sys_rst_s && hold_cnt_ff >= 2'(STRAP_HOLD_CYC - 1)) begin
					nxt_state = SLL_SAMPLE;
				end
			end
			SLL_SAMPLE: begin
				nxt_regulator_disable_strap = s1_sync_ff[1];
				nxt_irq_pin_function_strap  = s2_sync_ff[1];
				nxt_state = SLL_RUN;
			end
			SLL_RUN: begin
				if (sys_rst_s) begin
					nxt_state = SLL_RESET;
				end
			end
			default: nxt_state = SLL_RESET;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff                   <= SLL_RESET;
			regulator_disable_strap_ff <= REG_DIS_RST_VAL;
			irq_pin_function_strap_ff  <= IRQSEL_RST_VAL;
		end else begin
			state_ff                   <= nxt_state;
			regulator_disable_strap_ff <= nxt_regulator_disable_strap;
			irq_pin_function_strap_ff  <= nxt_irq_pin_function_strap;
		end
	end

	// Blink timer and registered pin drives.
	always_comb begin
		nxt_blink_cnt = blink_cnt_ff;
		nxt_blink     = blink_ff;
		if (!link_activity) begin
			nxt_blink_cnt = 32'h0;
			nxt_blink     = 1'h0;
		end else if (blink_cnt_ff >= 32'(BLINK_CYC - 1)) begin
			nxt_blink_cnt = 32'h0;
			nxt_blink     = !blink_ff;
		end else begin
			nxt_blink_cnt = blink_cnt_ff + 32'h1;
		end
		nxt_act_led = link_up && !blink_ff;
		nxt_spd_led = speed_100 && link_up && !line_isolate;
		nxt_int_n   = nxt_irq_pin_function_strap ? !phy_irq : 1'h1;
		nxt_txsym4  = nxt_irq_pin_function_strap ? 1'h0 : tx_error;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			blink_cnt_ff <= 32'h0;
			blink_ff     <= 1'h0;
			act_led_ff   <= 1'h0;
			spd_led_ff   <= 1'h0;
			int_n_ff     <= 1'h1;
			txsym4_ff    <= 1'h0;
		end else begin
			blink_cnt_ff <= nxt_blink_cnt;
			blink_ff     <= nxt_blink;
			act_led_ff   <= nxt_act_led;
			spd_led_ff   <= nxt_spd_led;
			int_n_ff     <= nxt_int_n;
			txsym4_ff    <= nxt_txsym4;
		end
	end

	// Pins are released as inputs until straps are captured.
	assign link_activity_led        = act_led_ff;
	assign link_speed_led           = spd_led_ff;
	assign link_activity_led_oe_n   = (state_ff != SLL_RUN);
	assign link_speed_led_oe_n      = (state_ff != SLL_RUN);
	assign regulator_off            = regulator_disable_strap_ff;
	assign irq_mode                 = irq_pin_function_strap_ff;
	assign interrupt_request_n      = int_n_ff;
	assign transmit_symbol_bit_four = txsym4_ff;

	strap_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_SAMPLE |=> regulator_disable_strap_ff == $past(s1_sync_ff[1])
		&& irq_pin_function_strap_ff == $past(s2_sync_ff[1]))
		else $error("Strap not captured.");
	hold_wait_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_SAMPLE |-> $past(state_ff, 2) == SLL_RESET)
		else $error("Strap sampled before pads settled.");
	sample_once_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_SAMPLE |=> state_ff == SLL_RUN)
		else $error("Sample state not left.");
	strap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RUN ##1 state_ff == SLL_RUN |-> $stable(regulator_disable_strap_ff))
		else $error("Strap changed while running.");
	oe_release_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff != SLL_RUN |-> link_activity_led_oe_n && link_speed_led_oe_n)
		else $error("Pad driven before capture.");

	reset_entry_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RUN && !rst_sync_ff[1] |=> state_ff == SLL_RESET)
		else $error("System reset ignored.");
	rst_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RESET && sys_rst_s |=> state_ff == SLL_RESET)
		else $error("Reset state left while reset held.");

	act_led_a: assert property (@(posedge clk) disable iff (!rstn)
		!link_up |=> !link_activity_led)
		else $error("Activity LED lit without link.");
	led_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		link_up && !link_activity ##1 link_up |=> link_activity_led)
		else $error("Activity LED dark on idle link.");
	blink_dark_a: assert property (@(posedge clk) disable iff (!rstn)
		link_up && blink_ff |=> !link_activity_led)
		else $error("Activity LED lit in dark blink phase.");
	speed_led_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> link_speed_led == $past(speed_100 && link_up && !line_isolate))
		else $error("Speed LED wrong.");
	speed_iso_a: assert property (@(posedge clk) disable iff (!rstn)
		line_isolate |=> !link_speed_led)
		else $error("Speed LED lit while isolated.");
	speed_10_a: assert property (@(posedge clk) disable iff (!rstn)
		!speed_100 |=> !link_speed_led)
		else $error("Speed LED lit at low speed.");

	reg_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!$past(state_ff == SLL_SAMPLE) |-> $stable(regulator_off) && $stable(irq_mode))
		else $error("Strap outputs changed outside capture.");
	irq_pin_a: assert property (@(posedge clk) disable iff (!rstn)
		!irq_mode |-> interrupt_request_n)
		else $error("Interrupt driven in transmit mode.");
	irq_drive_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RUN && irq_mode && phy_irq |=> !interrupt_request_n)
		else $error("Interrupt not driven.");
	txsym_drive_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RUN && !irq_mode |=> transmit_symbol_bit_four == $past(tx_error))
		else $error("Transmit symbol bit not driven.");
	txsym_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		irq_mode |-> !transmit_symbol_bit_four)
		else $error("Transmit symbol bit driven in interrupt mode.");

	run_cov: cover property (@(posedge clk) disable iff (!rstn) state_ff == SLL_RUN);
	regulator_disable_strap_cov: cover property (@(posedge clk) disable iff (!rstn) regulator_off);
	sym4_cov: cover property (@(posedge clk) disable iff (!rstn) !irq_mode && state_ff == SLL_RUN);
	blink_cov: cover property (@(posedge clk) disable iff (!rstn) link_up && blink_ff);
	sysrst_cov: cover property (@(posedge clk) disable iff (!rstn)
		state_ff == SLL_RUN ##1 state_ff == SLL_RESET);
endmodule
